//--- inc/iflc_pkg.sv
// Package of constants for the in-band flow control block.
package iflc_pkg;
   // Register indices on the plain register port.
   localparam logic [3:0] ADDR_MODE0 = 4'h0;
   localparam logic [3:0] ADDR_FLOW_MODE = 4'h1;
   localparam logic [3:0] ADDR_RESUME_CHAR = 4'h2;
   localparam logic [3:0] ADDR_PAUSE_CHAR = 4'h3;
   localparam logic [3:0] ADDR_WAKE_CHAR = 4'h4;
   localparam logic [3:0] ADDR_FLOW_STATUS = 4'h5;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
   localparam logic [3:0] ADDR_COMMAND = 4'h8;
   // Field positions.
   localparam int MODE0_STRIP_FLOW_BIT = 7;
   localparam int MODE0_STRIP_WAKE_BIT = 6;
   localparam int MODE0_REC_EN_BIT = 0;
   localparam int FLOW_TRANSP_BIT = 7;
   localparam int FLOW_MODE_HI = 3;
   localparam int FLOW_MODE_LO = 2;
   localparam int IRQ_FLOW_BIT = 4;
   localparam int STAT_RESUME_SEEN_BIT = 7;
   localparam int STAT_PAUSE_SEEN_BIT = 6;
   localparam int STAT_TX_HELD_BIT = 5;
   localparam int STAT_PAUSE_OUT_BIT = 4;
   localparam int CMD_CODE_HI = 7;
   localparam int CMD_CODE_LO = 3;
   // Flow mode encodings.
   localparam logic [1:0] MODE_HOST = 2'h0;
   localparam logic [1:0] MODE_AUTO_TX = 2'h1;
   localparam logic [1:0] MODE_AUTO_RX = 2'h2;
   localparam logic [1:0] MODE_AUTO_BOTH = 2'h3;
   // Command codes in the upper command field.
   localparam logic [4:0] CMD_TX_RESET = 5'h03;
   localparam logic [4:0] CMD_HOLD_TX = 5'h12;
   localparam logic [4:0] CMD_SEND_RESUME = 5'h14;
   localparam logic [4:0] CMD_SEND_PAUSE = 5'h15;
   localparam logic [4:0] CMD_RELEASE_TX = 5'h16;
   localparam logic [4:0] CMD_CANCEL_SEND = 5'h17;
   // Transmitter enable field in the low command bits.
   localparam logic [1:0] CMD_TX_ENABLE = 2'h1;
   localparam logic [1:0] CMD_TX_DISABLE = 2'h2;
   // Reset values.
   localparam logic [7:0] RESUME_CHAR_RST = 8'h11;
   localparam logic [7:0] PAUSE_CHAR_RST = 8'h13;
   localparam logic [7:0] WAKE_CHAR_RST = 8'h00;
   localparam logic [7:0] REG_RST = 8'h00;
   // Receive fill thresholds.
   localparam int RX_HIGH_LEVEL = 240;
   localparam int RX_LOW_LEVEL = 16;
   localparam int RX_FILL_W = 9;
endpackage

//--- hw/iflc_char_match.sv
// Comparator of a received character against the three programmed characters.
`timescale 1ns/10ps
module iflc_char_match #(
   parameter int WIDTH = 8
) (
   input wire logic [WIDTH-1:0] i_char,
   input wire logic [WIDTH-1:0] i_resume_char,
   input wire logic [WIDTH-1:0] i_pause_char,
   input wire logic [WIDTH-1:0] i_wake_char,
   output logic o_resume_hit,
   output logic o_pause_hit,
   output logic o_wake_hit
);
   initial begin
      if (WIDTH < 5 || WIDTH > 9) begin
         $error("iflc_char_match: unsupported character width");
      end
   end

   // Plain equality; a break arrives as a zero character and compares alike.
   function automatic logic same(input logic [WIDTH-1:0] a,
                                 input logic [WIDTH-1:0] b);
      return a == b;
   endfunction

   // The comparators run in every mode.
   assign o_resume_hit = same(i_char, i_resume_char);
   assign o_pause_hit = same(i_char, i_pause_char);
   assign o_wake_hit = same(i_char, i_wake_char);
endmodule // iflc_char_match

//--- hw/iflc_flow_ctrl.sv
// In-band flow control and character stripping for one serial channel.
// Operation
// R1: Strip recognized control characters, still act.
// R2: Errored control characters are always stored.
// R3: Mode field selects host, auto tx, rx.
// R4: Transparency bit discards flow characters always; here only with recognition enabled and no error bit set.
// R5: Compare against current resume/pause registers.
// R6: Host hold stays until reset or release.
// R7: Repeated send commands harmless; each cancels other.
// R8: Auto tx: received pause stops transmitter.
// R9: Received resume or reset restarts transmitter.
// R10: Auto tx mode ignores transmitter commands.
// R11: Held transmitter still lets its FIFO fill.
// R12: Break zero character compares like data.
// R13: No recognition or store without FIFO room.
// R14: Errored flow characters still count as valid.
// R15: Auto rx: pause above 240, resume below 16.
// R16: Inserted character waits for current character.
// R17: Drop pending character if condition vanishes.
// R18: Track outstanding pause; mode 00 clears it.
// R19: Cancel drops pending sends, not in auto.
// R20: A started flow character is never aborted.
// R21: Events only on recognition; comparators always run.
// R22: Reset loads standard resume and pause characters.
// R23: Event gated by mask bit 4, status bit 4.
// R24: Reset disables recognition and its event.
// R25: Reading flow status clears recognition bits.
// R26: One pause per crossing; resume only if outstanding.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module iflc_flow_ctrl #(
   parameter int CHAR_W = 8,
   parameter int ERR_W = 3,
   parameter int FILL_W = iflc_pkg::RX_FILL_W
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_soft_rst,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_rx_valid,
   input wire logic [CHAR_W-1:0] i_rx_char,
   input wire logic [ERR_W-1:0] i_rx_err,
   input wire logic i_rx_room,
   input wire logic [FILL_W-1:0] i_rx_fill,
   output logic o_rxf_wr,
   output logic [CHAR_W-1:0] o_rxf_data,
   output logic [ERR_W-1:0] o_rxf_err,
   output logic o_tx_halt,
   output logic o_tx_enable,
   output logic o_tx_reset,
   output logic o_fc_req,
   output logic [CHAR_W-1:0] o_fc_char,
   input wire logic i_fc_take,
   output logic o_flow_irq
);
   initial begin
      if (CHAR_W != 8 || ERR_W < 1 || FILL_W < 9) begin
         $error("iflc_flow_ctrl: unsupported parameter values");
      end
   end

   localparam logic [FILL_W-1:0] HIGH_LVL =
      FILL_W'(iflc_pkg::RX_HIGH_LEVEL);
   localparam logic [FILL_W-1:0] LOW_LVL =
      FILL_W'(iflc_pkg::RX_LOW_LEVEL);

   logic rst, irq_mask, resume_seen, pause_seen, auto_hold, host_hold;
   logic pend_resume, pend_pause, pause_out, hit_resume, hit_pause;
   logic hit_wake, auto_tx, auto_rx, rec_en, accept, flow_hit, strip;
   logic cmd_wr, tx_cmd_ok, stat_rd, above_high, below_low;
   logic take_pause, take_resume;
   logic [7:0] mode0, flow_mode, resume_char, pause_char, wake_char;
   logic [1:0] mode;
   logic [4:0] cmd_code;

   // Both resets act alike; the software reset comes from this clock domain.
   assign rst = i_sys_rst | i_soft_rst;

   // Decode of the mode field and of the commands.
   assign mode = flow_mode[iflc_pkg::FLOW_MODE_HI:iflc_pkg::FLOW_MODE_LO];
   assign auto_tx = (mode == iflc_pkg::MODE_AUTO_TX) ||
                    (mode == iflc_pkg::MODE_AUTO_BOTH); // [R3]
   assign auto_rx = (mode == iflc_pkg::MODE_AUTO_RX) ||
                    (mode == iflc_pkg::MODE_AUTO_BOTH); // [R3]
   assign rec_en = mode0[iflc_pkg::MODE0_REC_EN_BIT];
   assign cmd_wr = i_wr && (i_addr == iflc_pkg::ADDR_COMMAND);
   assign cmd_code = i_wdata[iflc_pkg::CMD_CODE_HI:iflc_pkg::CMD_CODE_LO];
   assign tx_cmd_ok = cmd_wr && !auto_tx; // [R10]
   assign stat_rd = i_rd && (i_addr == iflc_pkg::ADDR_FLOW_STATUS);
   assign above_high = i_rx_fill > HIGH_LVL; // [R15]
   assign below_low = i_rx_fill < LOW_LVL; // [R15]
   assign take_pause = i_fc_take && pend_pause;
   assign take_resume = i_fc_take && !pend_pause && pend_resume;

   // The comparators see every received character, breaks included.
   iflc_char_match #(
      .WIDTH(CHAR_W)
   ) u_match (
      .i_char(i_rx_char), // [R12]
      .i_resume_char(resume_char), // [R5]
      .i_pause_char(pause_char), // [R5]
      .i_wake_char(wake_char),
      .o_resume_hit(hit_resume),
      .o_pause_hit(hit_pause),
      .o_wake_hit(hit_wake)
   );

   // A character counts only when the receive FIFO has room for it.
   assign accept = i_rx_valid && i_rx_room; // [R13]
   assign flow_hit = rec_en && accept && (hit_resume || hit_pause); // [R14]

   // Stripping drops flow or wake characters, with recognition enabled, unless an error bit is set.
   always_comb begin
      strip = 1'b0;
      if (rec_en && (i_rx_err == '0)) begin // [R2]
         if (hit_resume || hit_pause) begin
            strip = mode0[iflc_pkg::MODE0_STRIP_FLOW_BIT] ||
                    flow_mode[iflc_pkg::FLOW_TRANSP_BIT]; // [R1] [R4]
         end
         if (hit_wake && mode0[iflc_pkg::MODE0_STRIP_WAKE_BIT]) begin
            strip = 1'b1; // [R1]
         end
      end
   end

   // Write port of the receive FIFO, one flop stage behind the receiver.
   always_ff @(posedge i_mclk) begin
      if (rst) begin
         o_rxf_wr <= 1'b0;
         o_rxf_data <= '0;
         o_rxf_err <= '0;
      end else begin
         o_rxf_wr <= accept && !strip; // [R1] [R13]
         o_rxf_data <= i_rx_char;
         o_rxf_err <= i_rx_err; // [R14]
      end
   end

   // Configuration registers written by software.
   always_ff @(posedge i_mclk) begin
      if (rst) begin
         mode0 <= iflc_pkg::REG_RST; // [R24]
         flow_mode <= iflc_pkg::REG_RST;
         resume_char <= iflc_pkg::RESUME_CHAR_RST; // [R22]
         pause_char <= iflc_pkg::PAUSE_CHAR_RST; // [R22]
         wake_char <= iflc_pkg::WAKE_CHAR_RST;
         irq_mask <= 1'b0;
      end else if (i_wr) begin
         unique case (i_addr)
            iflc_pkg::ADDR_MODE0: mode0 <= i_wdata;
            iflc_pkg::ADDR_FLOW_MODE: flow_mode <= i_wdata;
            iflc_pkg::ADDR_RESUME_CHAR: resume_char <= i_wdata;
            iflc_pkg::ADDR_PAUSE_CHAR: pause_char <= i_wdata;
            iflc_pkg::ADDR_WAKE_CHAR: wake_char <= i_wdata;
            iflc_pkg::ADDR_IRQ_MASK: begin
               irq_mask <= i_wdata[iflc_pkg::IRQ_FLOW_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // Sticky recognition flags; a new hit wins over the clearing read.
   always_ff @(posedge i_mclk) begin
      if (rst) begin
         resume_seen <= 1'b0;
         pause_seen <= 1'b0;
      end else begin
         if (flow_hit && hit_resume) begin
            resume_seen <= 1'b1; // [R21]
         end else if (stat_rd) begin
            resume_seen <= 1'b0; // [R25]
         end
         if (flow_hit && hit_pause) begin
            pause_seen <= 1'b1; // [R21]
         end else if (stat_rd) begin
            pause_seen <= 1'b0; // [R25]
         end
      end
   end

   // Event to the interrupt arbiter, only from recognition.
   assign o_flow_irq = (resume_seen || pause_seen) && irq_mask; // [R23]

   // Automatic hold: a recognized pause stops in auto transmit mode, a recognized resume restarts, stored or stripped.
   always_ff @(posedge i_mclk) begin
      if (rst) begin
         auto_hold <= 1'b0; // [R9]
      end else if (flow_hit && hit_pause && auto_tx) begin
         auto_hold <= 1'b1; // [R8]
      end else if (flow_hit && hit_resume) begin
         auto_hold <= 1'b0; // [R9]
      end
   end

   // Host hold ends only by reset or the release command.
   always_ff @(posedge i_mclk) begin
      if (rst) begin
         host_hold <= 1'b0;
      end else if (cmd_wr && mode == iflc_pkg::MODE_HOST) begin
         if (cmd_code == iflc_pkg::CMD_HOLD_TX) begin
            host_hold <= 1'b1; // [R6]
         end else if (cmd_code == iflc_pkg::CMD_RELEASE_TX) begin
            host_hold <= 1'b0; // [R6]
         end
      end
   end

   // The transmitter finishes its current character, then idles.
   assign o_tx_halt = auto_hold || host_hold; // [R8] [R11]

   // Transmitter enable and reset, refused in auto transmit mode.
   always_ff @(posedge i_mclk) begin
      if (rst) begin
         o_tx_enable <= 1'b0;
         o_tx_reset <= 1'b0;
      end else begin
         o_tx_reset <= tx_cmd_ok &&
                       (cmd_code == iflc_pkg::CMD_TX_RESET); // [R10]
         if (tx_cmd_ok && i_wdata[1:0] == iflc_pkg::CMD_TX_ENABLE) begin
            o_tx_enable <= 1'b1; // [R10]
         end else if (tx_cmd_ok &&
                      i_wdata[1:0] == iflc_pkg::CMD_TX_DISABLE) begin
            o_tx_enable <= 1'b0; // [R10]
         end
      end
   end

   // Pending pause character: commands or the upper fill threshold.
   always_ff @(posedge i_mclk) begin
      if (rst) begin
         pend_pause <= 1'b0;
      end else if (take_pause) begin
         pend_pause <= 1'b0; // [R20]
      end else if (auto_rx) begin
         if (above_high && !pause_out) begin
            pend_pause <= 1'b1; // [R15] [R26]
         end else if (!above_high) begin
            pend_pause <= 1'b0; // [R17]
         end
      end else if (tx_cmd_ok) begin
         if (cmd_code == iflc_pkg::CMD_SEND_PAUSE) begin
            pend_pause <= 1'b1; // [R7]
         end else if (cmd_code == iflc_pkg::CMD_SEND_RESUME ||
                      cmd_code == iflc_pkg::CMD_TX_RESET) begin
            pend_pause <= 1'b0; // [R7]
         end else if (cmd_code == iflc_pkg::CMD_CANCEL_SEND) begin
            pend_pause <= 1'b0; // [R19]
         end
      end
   end

   // Pending resume character: commands or the lower fill threshold.
   always_ff @(posedge i_mclk) begin
      if (rst) begin
         pend_resume <= 1'b0;
      end else if (take_resume) begin
         pend_resume <= 1'b0; // [R20]
      end else if (auto_rx) begin
         if (below_low && pause_out) begin
            pend_resume <= 1'b1; // [R15] [R26]
         end else if (!below_low) begin
            pend_resume <= 1'b0; // [R17]
         end
      end else if (tx_cmd_ok) begin
         if (cmd_code == iflc_pkg::CMD_SEND_RESUME) begin
            pend_resume <= 1'b1; // [R7]
         end else if (cmd_code == iflc_pkg::CMD_SEND_PAUSE ||
                      cmd_code == iflc_pkg::CMD_TX_RESET) begin
            pend_resume <= 1'b0; // [R7]
         end else if (cmd_code == iflc_pkg::CMD_CANCEL_SEND) begin
            pend_resume <= 1'b0; // [R19]
         end
      end
   end

   // Outstanding pause tracking; writing host mode clears it.
   // A pause taken in the same cycle as that write still counts.
   always_ff @(posedge i_mclk) begin
      if (rst) begin
         pause_out <= 1'b0;
      end else if (take_pause) begin
         pause_out <= 1'b1; // [R18]
      end else if (i_wr && i_addr == iflc_pkg::ADDR_FLOW_MODE &&
                   i_wdata[iflc_pkg::FLOW_MODE_HI:iflc_pkg::FLOW_MODE_LO] ==
                   iflc_pkg::MODE_HOST) begin
         pause_out <= 1'b0; // [R18]
      end else if (take_resume) begin
         pause_out <= 1'b0; // [R18]
      end
   end

   // Insertion request; the transmitter takes it between characters.
   assign o_fc_req = pend_pause || pend_resume; // [R16]
   assign o_fc_char = pend_pause ? pause_char : resume_char;

   // Read port: data stand in the cycle after the read strobe only.
   always_ff @(posedge i_mclk) begin
      if (rst || !i_rd) begin
         o_rdata <= 8'h00;
      end else begin
         unique case (i_addr)
            iflc_pkg::ADDR_MODE0: o_rdata <= mode0;
            iflc_pkg::ADDR_FLOW_MODE: o_rdata <= flow_mode;
            iflc_pkg::ADDR_RESUME_CHAR: o_rdata <= resume_char;
            iflc_pkg::ADDR_PAUSE_CHAR: o_rdata <= pause_char;
            iflc_pkg::ADDR_WAKE_CHAR: o_rdata <= wake_char;
            iflc_pkg::ADDR_FLOW_STATUS: begin
               o_rdata <= {resume_seen, pause_seen, o_tx_halt, pause_out,
                           4'h0};
            end
            iflc_pkg::ADDR_IRQ_STATUS: begin
               o_rdata <= {3'h0, resume_seen || pause_seen, 4'h0}; // [R23]
            end
            iflc_pkg::ADDR_IRQ_MASK: o_rdata <= {3'h0, irq_mask, 4'h0};
            default: o_rdata <= 8'h00;
         endcase
      end
   end

   // Checks of the flow behaviour.
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (rst);

   overrun_nostore_a: assert property ( // [R13]
      i_rx_valid && !i_rx_room |=> !o_rxf_wr && $stable(auto_hold))
      else $error("overrun character affected the flow logic");
   strip_flow_a: assert property ( // [R4]
      accept && rec_en && hit_pause && i_rx_err == '0 &&
      flow_mode[iflc_pkg::FLOW_TRANSP_BIT] |=> !o_rxf_wr)
      else $error("flow character stored while transparent");
   err_store_a: assert property ( // [R2]
      accept && i_rx_err != '0 |=> o_rxf_wr && o_rxf_err == $past(i_rx_err))
      else $error("errored character not stored");
   auto_pause_a: assert property ( // [R8]
      flow_hit && hit_pause && auto_tx |=> o_tx_halt ##1
      (o_tx_halt || $past(flow_hit && hit_resume)))
      else $error("pause character did not halt transmitter");
   host_hold_a: assert property ( // [R6]
      host_hold && !(cmd_wr && cmd_code == iflc_pkg::CMD_RELEASE_TX)
      |=> o_tx_halt)
      else $error("host hold released without command");
   auto_cmd_a: assert property ( // [R10]
      cmd_wr && auto_tx |=> $stable(o_tx_enable) && !o_tx_reset)
      else $error("transmitter command acted in auto mode");
   high_pause_a: assert property ( // [R15]
      auto_rx && above_high && !pause_out && !o_fc_req |=> pend_pause)
      else $error("no pause queued above high level");
   vanish_a: assert property ( // [R17]
      auto_rx && !above_high && pend_pause && !i_fc_take |=> !pend_pause)
      else $error("stale pause still pending");
   mode_clear_a: assert property ( // [R18]
      i_wr && i_addr == iflc_pkg::ADDR_FLOW_MODE && i_wdata[3:2] == 2'h0
      && !take_pause |=> !pause_out)
      else $error("pause tracking not cleared");
   read_clear_a: assert property ( // [R25]
      stat_rd && !flow_hit |=> !resume_seen && !pause_seen)
      else $error("status read did not clear flags");
   irq_cause_a: assert property ( // [R21]
      $rose(resume_seen || pause_seen) |-> $past(flow_hit))
      else $error("event without recognition");

   auto_halt_c: cover property (flow_hit && hit_pause && auto_tx
      ##1 o_tx_halt);
   pause_sent_c: cover property (auto_rx && take_pause);
   resume_sent_c: cover property (auto_rx && take_resume);
endmodule // iflc_flow_ctrl

//--- dv/iflc_tx_peer.sv
// Behavioural model of the channel transmitter that inserts flow characters.
`timescale 1ns/10ps
module iflc_tx_peer #(
   parameter int DELAY = 3
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_fc_req,
   input wire logic [7:0] i_fc_char,
   input wire logic i_stall,
   output logic o_fc_take,
   output logic [7:0] o_last_char,
   output logic [7:0] o_taken
);
   logic [7:0] wait_cnt;

   // Takes a waiting character only between characters, after DELAY+1 cycles of request.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_fc_take <= 1'b0;
         wait_cnt <= 8'h00;
         o_last_char <= 8'h00;
         o_taken <= 8'h00;
      end else begin
         o_fc_take <= 1'b0;
         if (!i_fc_req || i_stall || o_fc_take) begin
            wait_cnt <= 8'h00;
         end else if (wait_cnt == 8'(DELAY)) begin
            o_fc_take <= 1'b1;
            o_last_char <= i_fc_char;
            o_taken <= o_taken + 8'h01;
            wait_cnt <= 8'h00;
         end else begin
            wait_cnt <= wait_cnt + 8'h01;
         end
      end
   end
endmodule // iflc_tx_peer

//--- dv/inband_flow_control_bench.sv
// Self-checking testbench of the in-band flow control block.
`timescale 1ns/10ps
module inband_flow_control_bench;
   logic clk, i_sys_rst, i_soft_rst, i_wr, i_rd, i_rx_valid, i_rx_room;
   logic [3:0] i_addr;
   logic [7:0] i_wdata, i_rx_char, o_rdata, o_rxf_data, o_fc_char;
   logic [7:0] last_char, taken;
   logic [2:0] i_rx_err, o_rxf_err;
   logic [8:0] i_rx_fill;
   logic o_rxf_wr, o_tx_halt, o_tx_enable, o_tx_reset, o_fc_req;
   logic i_fc_take, o_flow_irq, stall;
   int mismatches, checked;

   iflc_flow_ctrl u_dut (.i_mclk(clk), .i_sys_rst(i_sys_rst),
      .i_soft_rst(i_soft_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_valid(i_rx_valid),
      .i_rx_char(i_rx_char), .i_rx_err(i_rx_err), .i_rx_room(i_rx_room),
      .i_rx_fill(i_rx_fill), .o_rxf_wr(o_rxf_wr), .o_rxf_data(o_rxf_data),
      .o_rxf_err(o_rxf_err), .o_tx_halt(o_tx_halt),
      .o_tx_enable(o_tx_enable), .o_tx_reset(o_tx_reset),
      .o_fc_req(o_fc_req), .o_fc_char(o_fc_char), .i_fc_take(i_fc_take),
      .o_flow_irq(o_flow_irq));

   iflc_tx_peer u_peer (.i_mclk(clk), .i_rst(i_sys_rst | i_soft_rst),
      .i_fc_req(o_fc_req), .i_fc_char(o_fc_char), .i_stall(stall),
      .o_fc_take(i_fc_take), .o_last_char(last_char), .o_taken(taken));

   // Free-running clock of 8 ns.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [15:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge clk);
      i_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge clk);
      i_rd <= 1'b0;
      #1 chk($sformatf("reg %h", a), o_rdata, exp);
   endtask

   task automatic cmd(input logic [4:0] c, input logic [1:0] en);
      wr(iflc_pkg::ADDR_COMMAND, {c, 1'b0, en});
   endtask

   // Presents one received character and checks the store decision.
   task automatic rx(input logic [7:0] c, input logic [2:0] e,
                     input logic room, input logic exp_wr);
      @(posedge clk);
      i_rx_valid <= 1'b1;
      i_rx_char <= c;
      i_rx_err <= e;
      i_rx_room <= room;
      @(posedge clk);
      i_rx_valid <= 1'b0;
      i_rx_room <= 1'b1;
      #1 chk("rxf_wr", o_rxf_wr, exp_wr);
      if (exp_wr) begin
         chk("rxf_data", {o_rxf_err, o_rxf_data}, {e, c});
      end
   endtask

   task automatic fill(input logic [8:0] f);
      @(posedge clk);
      i_rx_fill <= f;
      repeat (3) @(posedge clk);
      #1;
   endtask

   // Waits a bounded time for the transmitter to take a flow character.
   task automatic take_one(input logic [7:0] exp);
      logic [7:0] n0;
      int k;
      n0 = taken;
      k = 0;
      @(posedge clk);
      stall <= 1'b0;
      while (taken == n0 && k < 50) begin
         @(posedge clk);
         k++;
      end
      repeat (2) @(posedge clk);
      stall <= 1'b1;
      #1 chk("taken char", last_char, exp);
      chk("req after take", o_fc_req, 1'b0);
   endtask

   // Cuts a hung run short.
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      {i_soft_rst, i_wr, i_rd, i_rx_valid, i_addr, i_wdata} = '0;
      {i_rx_char, i_rx_err, i_rx_fill} = '0;
      i_rx_room = 1'b1;
      stall = 1'b1;
      i_sys_rst = 1'b1;
      repeat (3) @(posedge clk);
      i_sys_rst <= 1'b0;
      // Reset values, an unmapped place and the idle insertion character.
      rd(iflc_pkg::ADDR_RESUME_CHAR, 8'h11);
      rd(iflc_pkg::ADDR_PAUSE_CHAR, 8'h13);
      rd(4'hf, 8'h00);
      chk("fc_char", o_fc_char, 8'h11);
      $display("test reset done");
      // Automatic transmit control with stripping and refusals.
      wr(iflc_pkg::ADDR_IRQ_MASK, 8'h10);
      wr(iflc_pkg::ADDR_MODE0, 8'h01);
      wr(iflc_pkg::ADDR_FLOW_MODE, 8'h04);
      rx(8'h13, 3'h0, 1'b1, 1'b1);
      chk("halt", o_tx_halt, 1'b1);
      chk("irq", o_flow_irq, 1'b1);
      rd(iflc_pkg::ADDR_IRQ_STATUS, 8'h10);
      cmd(iflc_pkg::CMD_RELEASE_TX, 2'h0);
      chk("halt ignored cmd", o_tx_halt, 1'b1);
      cmd(iflc_pkg::CMD_TX_RESET, iflc_pkg::CMD_TX_ENABLE);
      chk("auto tx cmd", {o_tx_reset, o_tx_enable}, 2'h0);
      rd(iflc_pkg::ADDR_FLOW_STATUS, 8'h60);
      rd(iflc_pkg::ADDR_FLOW_STATUS, 8'h20);
      rx(8'h11, 3'h0, 1'b0, 1'b0);
      chk("halt no room", o_tx_halt, 1'b1);
      rx(8'h11, 3'h0, 1'b1, 1'b1);
      chk("halt resumed", o_tx_halt, 1'b0);
      wr(iflc_pkg::ADDR_MODE0, 8'h81);
      rx(8'h13, 3'h0, 1'b1, 1'b0);
      chk("halt stripped", o_tx_halt, 1'b1);
      rx(8'h11, 3'h4, 1'b1, 1'b1);
      chk("halt err resume", o_tx_halt, 1'b0);
      $display("test auto transmit done");
      // Transparency bit, a changed pause character and a break.
      wr(iflc_pkg::ADDR_MODE0, 8'h01);
      wr(iflc_pkg::ADDR_FLOW_MODE, 8'h84);
      rx(8'h11, 3'h0, 1'b1, 1'b0);
      wr(iflc_pkg::ADDR_PAUSE_CHAR, 8'h00);
      rx(8'h13, 3'h0, 1'b1, 1'b1);
      chk("halt old char", o_tx_halt, 1'b0);
      rx(8'h00, 3'h0, 1'b1, 1'b0);
      chk("halt break", o_tx_halt, 1'b1);
      @(posedge clk);
      i_soft_rst <= 1'b1;
      @(posedge clk);
      i_soft_rst <= 1'b0;
      #1 chk("halt soft reset", o_tx_halt, 1'b0);
      rd(iflc_pkg::ADDR_PAUSE_CHAR, 8'h13);
      wr(iflc_pkg::ADDR_FLOW_MODE, 8'h04);
      rx(8'h13, 3'h0, 1'b1, 1'b1);
      chk("halt unarmed", o_tx_halt, 1'b0);
      $display("test transparency done");
      // Host mode hold, release and general detection.
      wr(iflc_pkg::ADDR_FLOW_MODE, 8'h00);
      wr(iflc_pkg::ADDR_MODE0, 8'h01);
      wr(iflc_pkg::ADDR_IRQ_MASK, 8'h10);
      cmd(iflc_pkg::CMD_HOLD_TX, 2'h0);
      chk("halt hold", o_tx_halt, 1'b1);
      rx(8'h11, 3'h0, 1'b1, 1'b1);
      chk("host irq", o_flow_irq, 1'b1);
      cmd(5'h00, iflc_pkg::CMD_TX_DISABLE);
      cmd(5'h00, iflc_pkg::CMD_TX_ENABLE);
      chk("enable", o_tx_enable, 1'b1);
      chk("halt toggled", o_tx_halt, 1'b1);
      cmd(iflc_pkg::CMD_RELEASE_TX, 2'h0);
      chk("halt release", o_tx_halt, 1'b0);
      rd(iflc_pkg::ADDR_FLOW_STATUS, 8'h80);
      $display("test host hold done");
      // Host send commands, repeats and cancellation.
      cmd(iflc_pkg::CMD_SEND_PAUSE, 2'h0);
      cmd(iflc_pkg::CMD_SEND_PAUSE, 2'h0);
      chk("req pause", {o_fc_req, o_fc_char}, 9'h113);
      cmd(iflc_pkg::CMD_CANCEL_SEND, 2'h0);
      chk("req cancelled", o_fc_req, 1'b0);
      cmd(iflc_pkg::CMD_SEND_PAUSE, 2'h0);
      cmd(iflc_pkg::CMD_TX_RESET, 2'h0);
      chk("tx reset", {o_tx_reset, o_fc_req}, 2'h2);
      cmd(iflc_pkg::CMD_SEND_PAUSE, 2'h0);
      cmd(iflc_pkg::CMD_SEND_RESUME, 2'h0);
      chk("req resume", {o_fc_req, o_fc_char}, 9'h111);
      take_one(8'h11);
      chk("no send irq", o_flow_irq, 1'b0);
      $display("test host send done");
      // Automatic receive control around both thresholds.
      wr(iflc_pkg::ADDR_FLOW_MODE, 8'h08);
      fill(9'd240);
      chk("req at 240", o_fc_req, 1'b0);
      fill(9'd241);
      chk("req pause", {o_fc_req, o_fc_char}, 9'h113);
      cmd(iflc_pkg::CMD_CANCEL_SEND, 2'h0);
      chk("cancel in auto", o_fc_req, 1'b1);
      take_one(8'h13);
      rd(iflc_pkg::ADDR_FLOW_STATUS, 8'h10);
      fill(9'd16);
      chk("req at 16", o_fc_req, 1'b0);
      fill(9'd15);
      chk("req resume", {o_fc_req, o_fc_char}, 9'h111);
      fill(9'd200);
      chk("req withdrawn", o_fc_req, 1'b0);
      fill(9'd15);
      take_one(8'h11);
      fill(9'd10);
      chk("no extra resume", o_fc_req, 1'b0);
      fill(9'd241);
      take_one(8'h13);
      wr(iflc_pkg::ADDR_FLOW_MODE, 8'h00);
      fill(9'd10);
      chk("no resume on exit", o_fc_req, 1'b0);
      rd(iflc_pkg::ADDR_FLOW_STATUS, 8'h00);
      $display("test auto receive done");
      tally_and_finish();
   end
endmodule // inband_flow_control_bench
